// ===== src/gmp_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 gauge measurement and power control block. Assumes a 125 MHz core clock.
*/
`ifndef GMP_MAP_SVH
`define GMP_MAP_SVH

// Register byte offsets on the AXI4-Lite port
`define GMP_OFF_CTRL 8'h00
`define GMP_OFF_GAIN 8'h04
`define GMP_OFF_FGAIN 8'h08
`define GMP_OFF_VOLT 8'h0c
`define GMP_OFF_TEMP 8'h10
`define GMP_OFF_CURR 8'h14
`define GMP_OFF_AVG 8'h18
`define GMP_OFF_STAT 8'h1c

// Control and status field positions
`define GMP_CTRL_IDLE 0
`define GMP_CTRL_UV 1
`define GMP_STAT_SLEEP 0
`define GMP_STAT_UV 1
`define GMP_STAT_HIGH 2
`define GMP_STAT_INHIB 3
`define GMP_STAT_OFFS 4

// Reset values; gain 400h is unity
`define GMP_GAIN_RESET 11'h400
`define GMP_CTRL_RESET 2'h0

// Measurement scaling
`define GMP_UV_THR 16'sd502
`define GMP_VOLT_MAX 16'sh03ff
`define GMP_VOLT_MIN 16'shfc00
`define GMP_SAMPLE_SHIFT 16
`define GMP_GAIN_SHIFT 10
`define GMP_OFFS_IDX 10'h3ff
`define GMP_RESP_OK 2'h0
`define GMP_RESP_ERR 2'h2

// Times in their own unit and derived cycle counts
`define GMP_CLK_KHZ 125000
`define GMP_SLEEP_MS 2000
`define GMP_MEAS_MS 440
`define GMP_CONV_MS 3515
`define GMP_SLEEP_CYC (`GMP_SLEEP_MS * `GMP_CLK_KHZ)
`define GMP_MEAS_CYC (`GMP_MEAS_MS * `GMP_CLK_KHZ)
`define GMP_CONV_CYC (`GMP_CONV_MS * `GMP_CLK_KHZ)

`endif

// ===== src/gmp_pkg.sv
/*
 Types of the gauge measurement and power control block.
 Assumes gmp_map.svh for all numeric constants.
*/
package gmp_pkg;

   typedef enum logic [1:0] {GMP_ACTIVE, GMP_IDLE_SLEEP, GMP_UV_SLEEP} gmp_mode_t;

   // Whole state of the block, registered as one word
   typedef struct packed {
      gmp_mode_t mode;
      logic awake;
      logic ent_high;
      logic prev_line;
      logic inhibit;
      logic [28:0] slp_cnt;
      logic [28:0] meas_cnt;
      logic [28:0] conv_cnt;
      logic signed [47:0] sum;
      logic signed [47:0] offs;
      logic [9:0] conv_idx;
      logic offsel;
      logic [2:0] avg_idx;
      logic [7:0][15:0] hist;
      logic [15:0] curr;
      logic [15:0] avg;
      logic [15:0] volt;
      logic [15:0] temp;
      logic [15:0] chg;
      logic chg_stb;
      logic [1:0] ctrl;
      logic [10:0] gain;
      logic awg;
      logic wg;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } gmp_state_t;

endpackage : gmp_pkg

// ===== src/gmp_measure_power.sv
/*
 Measurement sequencing and power-mode control of a battery gauge, with an
 AXI4-Lite register slave. Assumes all inputs synchronous to CLK, a converter
 front end giving one SENSE_SAMPLE per SENSE_VALID pulse (about 18.6 kHz), and
 a bus protocol engine that reads PRESENCE_INHIBIT.

*/
`timescale 1ns/1ps
`include "gmp_map.svh"

module gmp_measure_power #(
   parameter int SLEEP_CYC = `GMP_SLEEP_CYC,
   parameter int MEAS_CYC = `GMP_MEAS_CYC,
   parameter int CONV_CYC = `GMP_CONV_CYC,
   parameter logic [10:0] FACTORY_GAIN = `GMP_GAIN_RESET
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic DQ_IN,
   input wire logic signed [15:0] CELL_VOLTAGE_INPUT,
   input wire logic signed [15:0] TEMP_SAMPLE,
   input wire logic signed [15:0] SENSE_SAMPLE,
   input wire logic SENSE_VALID,
   output logic ACTIVE,
   output logic OFFSET_SEL,
   output logic PRESENCE_INHIBIT,
   output logic [15:0] CHARGE_VAL,
   output logic CHARGE_STB
);

   gmp_pkg::gmp_state_t s;
   gmp_pkg::gmp_state_t next_s;
   logic reached;
   logic steady;
   logic meas_end;
   logic conv_end;
   logic signed [47:0] raw;
   logic signed [47:0] prod;
   logic signed [47:0] asum;

   // Saturate a wide signed value into the 16-bit result format
   function automatic logic [15:0] sat16(input logic signed [47:0] v);
      if (v > 48'sh7fff) begin
         return 16'h7fff;
      end
      if (v < -48'sh8000) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction : sat16

   // Whether a byte offset holds a register
   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `GMP_OFF_STAT);
   endfunction : mapped

   // Read data for one offset; factory copy is a constant, never the live gain
   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                         input gmp_pkg::gmp_state_t st);
      logic [31:0] d;
      d = 32'h0;
      case (a)
         `GMP_OFF_CTRL: d[1:0] = st.ctrl;
         `GMP_OFF_GAIN: d[10:0] = st.gain;
         `GMP_OFF_FGAIN: d[10:0] = FACTORY_GAIN;
         `GMP_OFF_VOLT: d = {{16{st.volt[15]}}, st.volt};
         `GMP_OFF_TEMP: d = {{16{st.temp[15]}}, st.temp};
         `GMP_OFF_CURR: d = {{16{st.curr[15]}}, st.curr};
         `GMP_OFF_AVG: d = {{16{st.avg[15]}}, st.avg};
         `GMP_OFF_STAT: begin
            d[`GMP_STAT_SLEEP] = !st.awake;
            d[`GMP_STAT_UV] = (st.mode == gmp_pkg::GMP_UV_SLEEP);
            d[`GMP_STAT_HIGH] = st.ent_high;
            d[`GMP_STAT_INHIB] = st.inhibit;
            d[`GMP_STAT_OFFS] = st.offsel;
         end
         default: d = 32'h0;
      endcase
      return d;
   endfunction : rd_mux

   // Next state of the whole block
   always_comb begin
      next_s = s;
      next_s.chg_stb = 1'b0;
      next_s.prev_line = DQ_IN;
      steady = (DQ_IN == s.prev_line);
      reached = (s.slp_cnt >= 29'(SLEEP_CYC - 1)) && steady;
      meas_end = (s.meas_cnt >= 29'(MEAS_CYC - 1));
      conv_end = (s.conv_cnt >= 29'(CONV_CYC - 1));
      // Offset is removed before gain so the trim scales the true signal
      raw = (s.sum >>> `GMP_SAMPLE_SHIFT) - s.offs;
      prod = raw * $signed({37'h0, s.gain});
      asum = 48'sh0;

      // Power mode sequencing
      case (s.mode)
         gmp_pkg::GMP_ACTIVE: begin
            if (!steady) begin
               next_s.slp_cnt = 29'h0;
            end else if (!reached) begin
               next_s.slp_cnt = s.slp_cnt + 29'h1;
            end
            // Falling edge starts a reset pulse; presence may answer it
            if (!DQ_IN && s.prev_line) begin
               next_s.inhibit = 1'b0;
            end
            if (s.ctrl[`GMP_CTRL_IDLE] && !DQ_IN && reached) begin
               next_s.mode = gmp_pkg::GMP_IDLE_SLEEP;
            end else if (s.ctrl[`GMP_CTRL_UV] && reached
                         && ($signed(s.volt) < `GMP_UV_THR)) begin
               next_s.mode = gmp_pkg::GMP_UV_SLEEP;
               next_s.ent_high = DQ_IN;
            end
         end
         gmp_pkg::GMP_IDLE_SLEEP: begin
            if (DQ_IN) begin
               next_s.mode = gmp_pkg::GMP_ACTIVE;
               next_s.slp_cnt = 29'h0;
               next_s.inhibit = 1'b1;
            end
         end
         gmp_pkg::GMP_UV_SLEEP: begin
            // Only a line edge wakes; the enable bits do not
            if (!steady) begin
               next_s.mode = gmp_pkg::GMP_ACTIVE;
               next_s.slp_cnt = 29'h0;
               next_s.inhibit = !s.ent_high;
            end
         end
         default: begin
            next_s.mode = gmp_pkg::GMP_ACTIVE;
         end
      endcase
      next_s.awake = (next_s.mode == gmp_pkg::GMP_ACTIVE);

      // Measurement runs in active mode only; all results hold in sleep
      if (s.mode == gmp_pkg::GMP_ACTIVE) begin
         if (meas_end) begin
            next_s.meas_cnt = 29'h0;
            if (CELL_VOLTAGE_INPUT > `GMP_VOLT_MAX) begin
               next_s.volt = `GMP_VOLT_MAX;
            end else if (CELL_VOLTAGE_INPUT < `GMP_VOLT_MIN) begin
               next_s.volt = `GMP_VOLT_MIN;
            end else begin
               next_s.volt = CELL_VOLTAGE_INPUT;
            end
            next_s.temp = TEMP_SAMPLE;
         end else begin
            next_s.meas_cnt = s.meas_cnt + 29'h1;
         end
         if (SENSE_VALID) begin
            next_s.sum = s.sum + {{32{SENSE_SAMPLE[15]}}, SENSE_SAMPLE};
         end
         if (conv_end) begin
            // A sample in the closing cycle is dropped; one in 65k
            next_s.conv_cnt = 29'h0;
            next_s.sum = 48'sh0;
            next_s.conv_idx = s.conv_idx + 10'h1;
            if (s.offsel) begin
               next_s.offs = s.sum >>> `GMP_SAMPLE_SHIFT;
               next_s.chg = s.curr;
            end else begin
               next_s.curr = sat16(prod >>> `GMP_GAIN_SHIFT);
               next_s.chg = next_s.curr;
            end
            next_s.chg_stb = 1'b1;
            next_s.hist[s.avg_idx] = next_s.curr;
            next_s.avg_idx = s.avg_idx + 3'h1;
            for (int i = 0; i < 8; i++) begin
               asum = asum + {{32{next_s.hist[i][15]}}, next_s.hist[i]};
            end
            if (s.avg_idx == 3'h7) begin
               next_s.avg = sat16(asum >>> 3);
            end
         end else begin
            next_s.conv_cnt = s.conv_cnt + 29'h1;
         end
      end
      next_s.offsel = (next_s.conv_idx == `GMP_OFFS_IDX);

      // AXI4-Lite write: address and data taken in either order
      if (s.awready && AWVALID) begin
         next_s.awg = 1'b1;
         next_s.waddr = AWADDR;
      end
      if (s.wready && WVALID) begin
         next_s.wg = 1'b1;
         next_s.wdata = WDATA;
         next_s.wstrb = WSTRB;
      end
      if (s.bvalid && BREADY) begin
         next_s.bvalid = 1'b0;
      end
      if (next_s.awg && next_s.wg && !next_s.bvalid) begin
         next_s.awg = 1'b0;
         next_s.wg = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(next_s.waddr) ? `GMP_RESP_OK : `GMP_RESP_ERR;
         if (next_s.waddr == `GMP_OFF_CTRL && next_s.wstrb[0]) begin
            next_s.ctrl = next_s.wdata[1:0];
         end
         if (next_s.waddr == `GMP_OFF_GAIN) begin
            if (next_s.wstrb[0]) begin
               next_s.gain[7:0] = next_s.wdata[7:0];
            end
            if (next_s.wstrb[1]) begin
               next_s.gain[10:8] = next_s.wdata[10:8];
            end
         end
      end

      // AXI4-Lite read: one cycle from address to data
      if (s.rvalid && RREADY) begin
         next_s.rvalid = 1'b0;
      end
      if (s.arready && ARVALID) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_mux(ARADDR, s);
         next_s.rresp = mapped(ARADDR) ? `GMP_RESP_OK : `GMP_RESP_ERR;
      end

      // Readies drop while a transfer is held, so only one is in flight
      next_s.awready = !next_s.awg && !next_s.bvalid;
      next_s.wready = !next_s.wg && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // State register; reset lands in active mode with gain at factory value
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s <= '0;
         s.awake <= 1'b1;
         s.gain <= FACTORY_GAIN;
         s.ctrl <= `GMP_CTRL_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register
   assign AWREADY = s.awready;
   assign WREADY = s.wready;
   assign BVALID = s.bvalid;
   assign BRESP = s.bresp;
   assign ARREADY = s.arready;
   assign RVALID = s.rvalid;
   assign RDATA = s.rdata;
   assign RRESP = s.rresp;
   assign ACTIVE = s.awake;
   assign OFFSET_SEL = s.offsel;
   assign PRESENCE_INHIBIT = s.inhibit;
   assign CHARGE_VAL = s.chg;
   assign CHARGE_STB = s.chg_stb;

   // Checks on mode sequencing and results
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   chk_power_active: assert property (
      !$past(RESETN) |-> ACTIVE && s.mode == gmp_pkg::GMP_ACTIVE)
      else $error("not active after reset");
   chk_sleep_hold: assert property (
      !ACTIVE && !$past(ACTIVE) |-> $stable(s.curr) && $stable(s.volt) && $stable(s.avg))
      else $error("results moved in sleep");
   chk_idle_entry: assert property (
      $rose(s.mode == gmp_pkg::GMP_IDLE_SLEEP)
      |-> !$past(DQ_IN) && $past(s.ctrl[0]) && $past(s.slp_cnt) >= 29'(SLEEP_CYC - 1))
      else $error("idle sleep without cause");
   chk_idle_wake: assert property (
      s.mode == gmp_pkg::GMP_IDLE_SLEEP && DQ_IN |=> ACTIVE ##0 PRESENCE_INHIBIT)
      else $error("idle sleep did not wake");
   chk_uv_entry: assert property (
      $rose(s.mode == gmp_pkg::GMP_UV_SLEEP)
      |-> $past(s.ctrl[1]) && $signed($past(s.volt)) < `GMP_UV_THR
          && s.ent_high == $past(DQ_IN))
      else $error("undervoltage sleep without cause");
   chk_uv_hold: assert property (
      s.mode == gmp_pkg::GMP_UV_SLEEP && DQ_IN == s.prev_line |=> !ACTIVE)
      else $error("undervoltage sleep left without activity");
   chk_uv_presence: assert property (
      s.mode == gmp_pkg::GMP_UV_SLEEP && DQ_IN != s.prev_line
      |=> ACTIVE && PRESENCE_INHIBIT == !$past(s.ent_high))
      else $error("wrong presence inhibit on wake");
   chk_volt_clamp: assert property (
      $signed(s.volt) <= `GMP_VOLT_MAX && $signed(s.volt) >= `GMP_VOLT_MIN)
      else $error("voltage out of range");
   chk_offset_hold: assert property (
      CHARGE_STB && $past(s.offsel) |-> CHARGE_VAL == s.curr && $stable(s.curr))
      else $error("offset conversion changed current");
   chk_timer_restart: assert property (
      ACTIVE && DQ_IN != s.prev_line |=> s.slp_cnt == 29'h0)
      else $error("sleep timer not restarted");
   chk_conv_period: assert property (
      CHARGE_STB |-> s.conv_cnt == 29'h0 ##1 !CHARGE_STB)
      else $error("conversion strobe mistimed");

   cov_idle_sleep: cover property ($rose(s.mode == gmp_pkg::GMP_IDLE_SLEEP));
   cov_uv_sleep: cover property ($rose(s.mode == gmp_pkg::GMP_UV_SLEEP));
   cov_offset_conv: cover property (CHARGE_STB && $past(s.offsel));
   cov_avg_update: cover property ($changed(s.avg));

endmodule : gmp_measure_power

// ===== tb/gmp_host_line.sv
/*
 Line master model that drives the single-wire bus line level into the block.
 Assumes the bench sets the idle level and pulses wake_req for one cycle.
*/
`timescale 1ns/1ps
module gmp_host_line #(
   parameter int PU_CYC = 6,
   parameter int RST_CYC = 10
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic idle_high,
   input wire logic wake_req,
   output logic dq,
   output logic busy
);
   logic [1:0] ph;
   int cnt;
   assign busy = (ph != 2'h0);
   // Phase 1 pulls the line up, phase 2 holds the bus reset low
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 2'h0;
         dq <= 1'b0; // Weak pull-down wins while nobody drives
         cnt <= 0;
      end else if (ph == 2'h0) begin
         if (wake_req && !dq) begin
            ph <= 2'h1; // A low line is pulled up before the reset pulse
            dq <= 1'b1;
            cnt <= PU_CYC;
         end else if (wake_req) begin
            ph <= 2'h2;
            dq <= 1'b0;
            cnt <= RST_CYC;
         end else begin
            dq <= idle_high; // Idle level held between frames
         end
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         ph <= (ph == 2'h1) ? 2'h2 : 2'h0;
         dq <= (ph == 2'h1) ? 1'b0 : 1'b1;
         cnt <= RST_CYC;
      end
   end
endmodule : gmp_host_line

// ===== tb/testbench.sv
/*
 Self-checking bench of the measurement and power control block.
 Assumes short counts: sleep 200, measure 50, conversion 40 cycles.
*/
`timescale 1ns/1ps
`include "gmp_map.svh"
module testbench;
   localparam int SLP = 200;
   localparam int MEAS = 50;
   localparam int CONV = 40;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] rs;
      logic [31:0] ex;} gmp_row_t;
   logic CLK = 0, RESETN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic SENSE_VALID = 0, idle_high = 0, wake_req = 0;
   logic [7:0] AWADDR = 0, ARADDR = 0;
   logic [31:0] WDATA = 0, q;
   logic [3:0] WSTRB = 0;
   logic signed [15:0] CELL_VOLTAGE_INPUT = 0, TEMP_SAMPLE = 0, SENSE_SAMPLE = 0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DQ_IN, ACTIVE, OFFSET_SEL;
   logic PRESENCE_INHIBIT, CHARGE_STB, busy;
   logic [1:0] BRESP, RRESP, r;
   logic [31:0] RDATA;
   logic [15:0] CHARGE_VAL;
   int mismatches = 0, checks = 0, n;
   // Register map, read-only copy and an unmapped place
   gmp_row_t rows [9] = '{
      '{1'b0, `GMP_OFF_CTRL, 32'h0, `GMP_RESP_OK, 32'h0},
      '{1'b0, `GMP_OFF_GAIN, 32'h0, `GMP_RESP_OK, 32'h400},
      '{1'b0, `GMP_OFF_FGAIN, 32'h0, `GMP_RESP_OK, 32'h400},
      '{1'b1, `GMP_OFF_FGAIN, 32'h123, `GMP_RESP_OK, 32'h0},
      '{1'b0, `GMP_OFF_FGAIN, 32'h0, `GMP_RESP_OK, 32'h400},
      '{1'b1, 8'h20, 32'h1, `GMP_RESP_ERR, 32'h0},
      '{1'b0, 8'h20, 32'h0, `GMP_RESP_ERR, 32'h0},
      '{1'b1, `GMP_OFF_GAIN, 32'h7ff, `GMP_RESP_OK, 32'h0},
      '{1'b0, `GMP_OFF_GAIN, 32'h0, `GMP_RESP_OK, 32'h7ff}};
   logic [15:0] cell_voltage_input [3] = '{16'h0500, 16'hf830, 16'h0064};
   logic [15:0] vex [3] = '{16'h03ff, 16'hfc00, 16'h0064};

   always #4 CLK = ~CLK;

   gmp_measure_power #(.SLEEP_CYC(SLP), .MEAS_CYC(MEAS), .CONV_CYC(CONV)) uut (
      .CLK(CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .DQ_IN(DQ_IN), .CELL_VOLTAGE_INPUT(CELL_VOLTAGE_INPUT), .TEMP_SAMPLE(TEMP_SAMPLE),
      .SENSE_SAMPLE(SENSE_SAMPLE), .SENSE_VALID(SENSE_VALID), .ACTIVE(ACTIVE),
      .OFFSET_SEL(OFFSET_SEL), .PRESENCE_INHIBIT(PRESENCE_INHIBIT),
      .CHARGE_VAL(CHARGE_VAL), .CHARGE_STB(CHARGE_STB));

   gmp_host_line host (.clk(CLK), .rst_n(RESETN), .idle_high(idle_high),
      .wake_req(wake_req), .dq(DQ_IN), .busy(busy));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks++;
      if (seen !== ex) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge CLK);
   endtask : cyc

   // Both channels offered together; each dropped on its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int k;
      k = 0;
      rs = 2'h3;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= 4'hf;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (k < 100) begin
         @(posedge CLK);
         k++;
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
         if (BREADY && BVALID) begin
            rs = BRESP;
            BREADY <= 1'b0;
            k = 100;
         end
      end
      // A missing answer counts against the run
      if (rs === 2'h3) begin
         mismatches++;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int k;
      k = 0;
      rs = 2'h3;
      d = 32'hx;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (k < 100) begin
         @(posedge CLK);
         k++;
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
         if (RREADY && RVALID) begin
            d = RDATA;
            rs = RRESP;
            RREADY <= 1'b0;
            k = 100;
         end
      end
      // A missing answer counts against the run
      if (rs === 2'h3) begin
         mismatches++;
      end
   endtask : rd

   task automatic conclude();
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   // The offset conversion alone needs about 41000 cycles
   initial begin
      #(8 * 90000);
      mismatches++;
      conclude();
   end

   initial begin
      cyc(10);
      RESETN <= 1'b1;
      cyc(2);
      chk("active", ACTIVE, 1);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d, r);
         else rd(rows[i].a, q, r);
         chk("resp", r, rows[i].rs);
         if (!rows[i].wr) chk("rdata", q, rows[i].ex);
      end
      // Voltage clamps at both ends, temperature loaded as given
      TEMP_SAMPLE <= 16'shffe8;
      foreach (cell_voltage_input[i]) begin
         CELL_VOLTAGE_INPUT <= cell_voltage_input[i];
         cyc(2 * MEAS + 2);
         rd(`GMP_OFF_VOLT, q, r);
         chk("volt", q[15:0], vex[i]);
      end
      rd(`GMP_OFF_TEMP, q, r);
      chk("temp", q[15:0], 16'hffe8);
      // Full negative scale at half gain: -20 halved
      wr(`GMP_OFF_GAIN, 32'h200, r);
      SENSE_SAMPLE <= 16'sh8000;
      SENSE_VALID <= 1'b1;
      cyc(18 * CONV);
      rd(`GMP_OFF_CURR, q, r);
      chk("curr", q[15:0], 16'hfff6);
      rd(`GMP_OFF_AVG, q, r);
      chk("avg", q[15:0], 16'hfff6);
      wr(`GMP_OFF_GAIN, 32'h400, r);
      SENSE_SAMPLE <= 16'sh7fff;
      idle_high <= 1'b1;
      cyc(3 * CONV);
      rd(`GMP_OFF_CURR, q, r);
      chk("curr", q[15:0], 16'h0013);
      // Idle sleep with one glitch that must restart the timer
      wr(`GMP_OFF_CTRL, 32'h1, r);
      idle_high <= 1'b0;
      cyc(SLP - 40);
      idle_high <= 1'b1;
      cyc(1);
      idle_high <= 1'b0;
      cyc(SLP - 5);
      chk("active", ACTIVE, 1);
      cyc(10);
      chk("active", ACTIVE, 0);
      rd(`GMP_OFF_STAT, q, r);
      chk("stat", q, 32'h1);
      SENSE_SAMPLE <= 16'sh8000;
      cyc(3 * CONV);
      rd(`GMP_OFF_CURR, q, r);
      chk("curr", q[15:0], 16'h0013);
      wake_req <= 1'b1;
      idle_high <= 1'b1;
      cyc(1);
      wake_req <= 1'b0;
      SENSE_SAMPLE <= 16'sh7fff;
      cyc(3);
      chk("active", ACTIVE, 1);
      chk("inhibit", PRESENCE_INHIBIT, 1);
      n = 0;
      while (busy && n < 100) begin
         cyc(1);
         n++;
      end
      cyc(2);
      chk("inhibit", PRESENCE_INHIBIT, 0);
      // Undervoltage sleep entered with the line high, then a direct reset
      wr(`GMP_OFF_CTRL, 32'h2, r);
      cyc(SLP + 10);
      chk("active", ACTIVE, 0);
      chk("inhibit", PRESENCE_INHIBIT, 0);
      rd(`GMP_OFF_STAT, q, r);
      chk("stat", q, 32'h7);
      cyc(2 * SLP);
      chk("active", ACTIVE, 0);
      wake_req <= 1'b1;
      cyc(1);
      wake_req <= 1'b0;
      cyc(3);
      chk("active", ACTIVE, 1);
      chk("inhibit", PRESENCE_INHIBIT, 0);
      wr(`GMP_OFF_CTRL, 32'h0, r);
      // Offset conversion: value held, then full offset removed
      n = 0;
      while (!OFFSET_SEL && n < 60000) begin
         cyc(1);
         n++;
      end
      chk("offsel", OFFSET_SEL, 1);
      rd(`GMP_OFF_CURR, q, r);
      chk("curr", q[15:0], 16'h0013);
      n = 0;
      while (!CHARGE_STB && n < 200) begin
         cyc(1);
         n++;
      end
      chk("charge", CHARGE_VAL, 16'h0013);
      cyc(2 * CONV + 5);
      rd(`GMP_OFF_CURR, q, r);
      chk("curr", q[15:0], 16'h0000);
      conclude();
   end
endmodule : testbench
